// ---- shared/lrx_pkg.sv ----
// Constants, types and mode decoding shared by the receive input select block
package lrx_pkg;

  // Clocking and line rates
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int E1_RATE_BPS = 2_048_000;
  localparam int T1_RATE_BPS = 1_544_000;
  // Bit period in core cycles, rounded down
  localparam logic [5:0] PER_E1 = 6'(CORE_CLK_HZ / E1_RATE_BPS);
  localparam logic [5:0] PER_T1 = 6'(CORE_CLK_HZ / T1_RATE_BPS);
  localparam logic [5:0] PHASE_ZERO = 6'h00;
  localparam logic [5:0] PHASE_ONE  = 6'h01;

  // Register port
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 8;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h01;
  localparam int         CTRL_W     = 5;
  localparam int         STAT_OVF   = 2;
  localparam logic [7:0] RD_ZERO    = 8'h00;

  // Receive code select values
  localparam logic [1:0] CODE_NRZ = 2'h0;
  localparam logic [1:0] CODE_CMI = 2'h1;
  localparam logic [1:0] CODE_AMI = 2'h2;

  // Pin vector positions
  localparam int PIN_CNT  = 6;
  localparam int IDX_LA   = 0;
  localparam int IDX_LB   = 1;
  localparam int IDX_RP   = 2;
  localparam int IDX_RN   = 3;
  localparam int IDX_OD   = 4;
  localparam int IDX_OC   = 5;

  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    LRX_M_ANALOG,
    LRX_M_DUAL,
    LRX_M_NRZ,
    LRX_M_CMI
  } lrx_mode_t;

  // Control register layout, bit 4 downward; all zero after reset
  typedef struct packed {
    logic       t1Rate;
    logic       activeHigh;
    logic [1:0] code;
    logic       digital;
  } lrx_ctrl_t;

  localparam lrx_ctrl_t CTRL_RESET = 5'h00;

  typedef struct packed {
    logic violation;
    logic data;
  } lrx_sym_t;

  function automatic lrx_mode_t lrx_decode_mode(input lrx_ctrl_t c);
    if (!c.digital) return LRX_M_ANALOG;
    if (c.code[1]) return LRX_M_DUAL;
    if (c.code == CODE_CMI) return LRX_M_CMI;
    return LRX_M_NRZ;
  endfunction

endpackage

// ---- core/lrx_input_select.sv ----
// Receive line input selection, clock recovery and symbol FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lrx_fifo
  import lrx_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memFf [DEPTH];
  logic [AW:0]      wrPtrFf;
  logic [AW:0]      rdPtrFf;
  logic             full;
  logic             empty;

  // Pointers carry one extra wrap bit; depth must be a power of two
  assign empty    = (wrPtrFf == rdPtrFf);
  assign full     = (wrPtrFf[AW] != rdPtrFf[AW]) && (wrPtrFf[AW-1:0] == rdPtrFf[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = memFf[rdPtrFf[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (inValid && !full) begin
      memFf[wrPtrFf[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrPtrFf <= '0;
      rdPtrFf <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtrFf <= wrPtrFf + 1'h1;
      end
      if (outReady && !empty) begin
        rdPtrFf <= rdPtrFf + 1'h1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module lrx_input_select
  import lrx_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  // Line pins, analog inputs as sliced comparator levels
  input  wire logic              analogRxLineA,
  input  wire logic              analogRxLineB,
  input  wire logic              rxRailPositiveIn,
  input  wire logic              rxRailNegativeIn,
  input  wire logic              opticalRxDataIn,
  input  wire logic              opticalRxClockIn,
  // Decoded symbol stream
  output logic                   symValid,
  output lrx_sym_t               symData,
  input  wire logic              symReady
);

  lrx_ctrl_t          ctrlFf;
  lrx_mode_t          modeFf;
  logic               overflowFf;
  logic [DATA_W-1:0]  nxt_rdData;
  logic [DATA_W-1:0]  regRdDataFf;
  logic [PIN_CNT-1:0] pinRaw;
  logic [PIN_CNT-1:0] sync1Ff;
  logic [PIN_CNT-1:0] sync2Ff;
  logic               inv;
  logic               posAct;
  logic               negAct;
  logic               optData;
  logic               optClk;
  logic               prevPosFf;
  logic               prevNegFf;
  logic               prevOptFf;
  logic               prevClkFf;
  logic               railMode;
  logic               railRise;
  logic               cmiFall;
  logic               clkFall;
  logic               resync;
  logic [5:0]         period;
  logic [5:0]         qtr;
  logic [5:0]         threeQtr;
  logic [5:0]         phaseFf;
  logic               firstPosFf;
  logic               firstNegFf;
  logic               firstOptFf;
  logic               lastPolFf;
  logic               seenPulseFf;
  logic               candValidFf;
  lrx_sym_t           candFf;
  logic               fifoReady;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrlFf <= CTRL_RESET;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      ctrlFf <= lrx_ctrl_t'(regWrData[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      modeFf <= LRX_M_ANALOG;
    end else begin
      modeFf <= lrx_decode_mode(ctrlFf);
    end
  end

  // Line data cannot be stalled, so a full FIFO loses the symbol; set beats clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      overflowFf <= 1'h0;
    end else if (candValidFf && !fifoReady) begin
      overflowFf <= 1'h1;
    end else if (regWr && regAddr == ADDR_STAT && regWrData[STAT_OVF]) begin
      overflowFf <= 1'h0;
    end
  end

  always_comb begin
    nxt_rdData = RD_ZERO;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL: nxt_rdData = DATA_W'(ctrlFf);
        ADDR_STAT: nxt_rdData = DATA_W'({symValid, overflowFf, modeFf});
        default:   nxt_rdData = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      regRdDataFf <= RD_ZERO;
    end else begin
      regRdDataFf <= nxt_rdData;
    end
  end
  assign regRdData = regRdDataFf;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pinRaw = {opticalRxClockIn, opticalRxDataIn, rxRailNegativeIn,
                   rxRailPositiveIn, analogRxLineB, analogRxLineA};

  for (genvar i = 0; i < PIN_CNT; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        sync1Ff[i] <= 1'h0;
        sync2Ff[i] <= 1'h0;
      end else begin
        sync1Ff[i] <= pinRaw[i];
        sync2Ff[i] <= sync1Ff[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input selection and edge detection
  assign inv      = !ctrlFf.activeHigh;
  assign railMode = (modeFf == LRX_M_ANALOG) || (modeFf == LRX_M_DUAL);
  // The analog slicer already delivers active-high pulses
  assign posAct   = (modeFf == LRX_M_ANALOG) ? sync2Ff[IDX_LA] : (sync2Ff[IDX_RP] ^ inv);
  assign negAct   = (modeFf == LRX_M_ANALOG) ? sync2Ff[IDX_LB] : (sync2Ff[IDX_RN] ^ inv);
  assign optData  = sync2Ff[IDX_OD] ^ inv;
  assign optClk   = sync2Ff[IDX_OC];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prevPosFf <= 1'h0;
      prevNegFf <= 1'h0;
      prevOptFf <= 1'h0;
      prevClkFf <= 1'h0;
    end else begin
      prevPosFf <= posAct;
      prevNegFf <= negAct;
      prevOptFf <= optData;
      prevClkFf <= optClk;
    end
  end

  assign railRise = railMode && ((posAct && !prevPosFf) || (negAct && !prevNegFf));
  // CMI falls only on bit boundaries, so a fall marks phase zero
  assign cmiFall  = (modeFf == LRX_M_CMI) && prevOptFf && !optData;
  // Clock pin is looked at only in optical NRZ mode
  assign clkFall  = (modeFf == LRX_M_NRZ) && prevClkFf && !optClk;
  assign resync   = railRise || cmiFall;

  //////////////////////////////////////////////////////////////////////////////
  // Phase counter of the digital PLL
  assign period   = ctrlFf.t1Rate ? PER_T1 : PER_E1;
  assign qtr      = period >> 2;
  assign threeQtr = period - qtr;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phaseFf <= PHASE_ZERO;
    end else if (modeFf == LRX_M_NRZ || resync) begin
      phaseFf <= PHASE_ZERO;
    end else if (phaseFf >= period - PHASE_ONE) begin
      phaseFf <= PHASE_ZERO;
    end else begin
      phaseFf <= phaseFf + PHASE_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      firstPosFf <= 1'h0;
      firstNegFf <= 1'h0;
      firstOptFf <= 1'h0;
    end else if (phaseFf == qtr) begin
      firstPosFf <= posAct;
      firstNegFf <= negAct;
      firstOptFf <= optData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Symbol decision and code checks
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      candValidFf <= 1'h0;
      candFf      <= '0;
      lastPolFf   <= 1'h0;
      seenPulseFf <= 1'h0;
    end else begin
      candValidFf <= 1'h0;
      if (clkFall) begin
        candValidFf <= 1'h1;
        candFf      <= '{violation: 1'h0, data: optData};
      end else if (modeFf == LRX_M_CMI && phaseFf == threeQtr) begin
        candValidFf <= 1'h1;
        // Equal halves carry a one; a high-then-low pair is illegal in CMI
        candFf      <= '{violation: firstOptFf && !optData, data: firstOptFf == optData};
      end else if (railMode && phaseFf == threeQtr) begin
        candValidFf <= 1'h1;
        // Only plain AMI flags repeated polarity; substitution codes reuse it legally
        candFf.data      <= firstPosFf || firstNegFf;
        candFf.violation <= (firstPosFf && firstNegFf) ||
                            (ctrlFf.code == CODE_AMI && seenPulseFf && firstPosFf != firstNegFf
                             && firstPosFf == lastPolFf);
        if (firstPosFf != firstNegFf) begin
          lastPolFf   <= firstPosFf;
          seenPulseFf <= 1'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Symbol FIFO
  lrx_fifo #(
    .WIDTH ($bits(lrx_sym_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inValid  (candValidFf),
    .inData   (candFf),
    .inReady  (fifoReady),
    .outValid (symValid),
    .outData  (symData),
    .outReady (symReady)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_analog_mode_select: assert property (!ctrlFf.digital |=> modeFf == LRX_M_ANALOG)
    else $error("analog inputs not selected with digital mode cleared");
  a_dual_rail_select: assert property (
    (ctrlFf.digital && ctrlFf.code[1]) |=> modeFf == LRX_M_DUAL)
    else $error("dual rail not selected");
  a_rail_pulse_sampled: assert property (
    (modeFf == LRX_M_DUAL && railRise && $stable(ctrlFf))
    |-> ##[1:40] (candValidFf && candFf.data))
    else $error("dual rail pulse not turned into a one");
  a_input_polarity_low: assert property (
    (modeFf == LRX_M_DUAL && !ctrlFf.activeHigh) |-> posAct == !sync2Ff[IDX_RP])
    else $error("active low rail not inverted");
  a_nrz_code_select: assert property (
    (ctrlFf.digital && ctrlFf.code == CODE_NRZ) |=> modeFf == LRX_M_NRZ)
    else $error("code 00 did not select clocked optical input");
  a_optical_mode_select: assert property (
    (ctrlFf.digital && !ctrlFf.code[1]) |=> (modeFf == LRX_M_NRZ || modeFf == LRX_M_CMI))
    else $error("single rail optical not selected");
  a_nrz_falling_sample: assert property (
    clkFall |=> (candValidFf && candFf.data == $past(optData)))
    else $error("optical data not taken on clock fall");
  a_cmi_code_select: assert property (
    (ctrlFf.digital && ctrlFf.code == CODE_CMI) |=> modeFf == LRX_M_CMI)
    else $error("code 01 did not select CMI recovery");
  a_cmi_clock_ignored: assert property (
    (modeFf == LRX_M_CMI && candValidFf) |-> $past(phaseFf) == $past(threeQtr))
    else $error("CMI symbol not timed by recovered phase");

  c_dual_rail_one: cover property (modeFf == LRX_M_DUAL && candValidFf && candFf.data);
  c_cmi_zero: cover property (modeFf == LRX_M_CMI && candValidFf && !candFf.data);
  c_nrz_symbol: cover property (modeFf == LRX_M_NRZ && candValidFf);
  c_fifo_overflow: cover property ($rose(overflowFf));

endmodule

// ---- dv/lrx_line_model.sv ----
// Line front end model driving the receive pins in every mode
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lrx_line_model (
  // Polarity of the digital pins other than the optical clock
  input  wire logic activeHigh,
  // Receive pins
  output logic      lineA,
  output logic      lineB,
  output logic      railPos,
  output logic      railNeg,
  output logic      optData,
  output logic      optClk
);
  logic pos = 1'b0;
  logic neg = 1'b0;
  logic dat = 1'b0;
  logic ana = 1'b0;

  assign lineA   = ana & pos;
  assign lineB   = ana & neg;
  assign railPos = (~ana & pos) ^ ~activeHigh;
  assign railNeg = (~ana & neg) ^ ~activeHigh;
  assign optData = dat ^ ~activeHigh;
  initial optClk = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Lead-in N,0 fixes the last pulse polarity whatever came before
  task automatic sendRail(input logic [15:0] s, input int per, input logic toAnalog);
    logic [19:0] u;
    u = {s, 4'h2};
    ana = toAnalog;
    for (int i = 0; i < 10; i++) begin
      {neg, pos} = u[2*i+:2];
      #(per * 10);
      {neg, pos} = 2'h0;
      #(per * 10);
    end
  endtask

  // Clock runs only within the frame
  task automatic sendNrz(input logic [15:0] s);
    for (int i = 0; i < 8; i++) begin
      optClk = 1'b1;
      dat = s[2*i];
      #80;
      optClk = 1'b0;
      #80;
    end
    dat = ~dat;
  endtask

  // Stray clock toggles each bit; two zero bits lead in for phase lock
  task automatic sendCmi(input logic [15:0] s, input int per);
    logic [19:0] u;
    logic        alt;
    u = {s, 4'h0};
    alt = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (u[2*i]) begin
        dat = alt;
        alt = ~alt;
        #(per * 20);
      end else begin
        dat = 1'b0;
        #(per * 10);
        dat = 1'b1;
        #(per * 10);
      end
      optClk = ~optClk;
    end
  endtask
endmodule

// ---- dv/lrx_input_select_tb.sv ----
// Self-checking bench for the receive input select block
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lrx_input_select_tb;
  import lrx_pkg::*;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  mode;
    logic [15:0] stim;
    logic [15:0] exp;
  } lrx_row_t;

  logic              core_clk  = 1'b0;
  logic              reset_n   = 1'b0;
  logic [ADDR_W-1:0] regAddr   = 8'h00;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic              lineA;
  logic              lineB;
  logic              railPos;
  logic              railNeg;
  logic              optData;
  logic              optClk;
  logic              symValid;
  lrx_sym_t          symData;
  logic              symReady  = 1'b1;
  logic              pol       = 1'b0;
  int                numErrors = 0;
  int                cmpCount  = 0;
  lrx_sym_t          got[$];

  // Symbols per bit, LSB first: 1 pos, 2 neg, 3 both rails
  lrx_row_t rows [8] = '{
    '{8'h00, 2'h0, 16'h8961, 16'h4551},
    '{8'h05, 2'h1, 16'h8961, 16'hC751},
    '{8'h07, 2'h1, 16'h28E1, 16'h14D1},
    '{8'h0D, 2'h1, 16'h8961, 16'hC751},
    '{8'h01, 2'h2, 16'h1051, 16'h1051},
    '{8'h09, 2'h2, 16'h1051, 16'h1051},
    '{8'h03, 2'h3, 16'h4114, 16'h4114},
    '{8'h1B, 2'h3, 16'h4114, 16'h4114}
  };

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) if (symValid === 1'b1 && symReady === 1'b1) got.push_back(symData);

  lrx_input_select dut (
    .core_clk         (core_clk),
    .reset_n          (reset_n),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWr            (regWr),
    .regRd            (regRd),
    .regRdData        (regRdData),
    .analogRxLineA    (lineA),
    .analogRxLineB    (lineB),
    .rxRailPositiveIn (railPos),
    .rxRailNegativeIn (railNeg),
    .opticalRxDataIn  (optData),
    .opticalRxClockIn (optClk),
    .symValid         (symValid),
    .symData          (symData),
    .symReady         (symReady)
  );

  lrx_line_model line (
    .activeHigh (pol),
    .lineA      (lineA),
    .lineB      (lineB),
    .railPos    (railPos),
    .railNeg    (railNeg),
    .optData    (optData),
    .optClk     (optClk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmpCount++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Looks for the expected eight symbols back to back in what was popped
  function automatic logic [15:0] seek(input logic [15:0] e);
    logic [15:0] w;
    w = 'x;
    for (int i = 0; i + 8 <= got.size(); i++) begin
      for (int k = 0; k < 8; k++) w[2*k+:2] = got[i+k];
      if (w === e) return w;
    end
    return w;
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    lrx_row_t   r;
    logic [7:0] v;
    int         per;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    regRead(ADDR_CTRL, v);
    chk(16'(v), 16'(CTRL_RESET));
    regRead(ADDR_STAT, v);
    chk(16'(v), 16'h0000);
    foreach (rows[i]) begin
      r = rows[i];
      per = r.ctrl[4] ? int'(PER_T1) : int'(PER_E1);
      // Pin polarity flips on the edge so the synced pins and the new control bit agree
      pol <= r.ctrl[3];
      regWrite(ADDR_CTRL, r.ctrl);
      regRead(ADDR_STAT, v);
      chk(16'(v[1:0]), 16'(r.mode));
      got.delete();
      case (r.mode)
        2'h2: line.sendNrz(r.stim);
        2'h3: line.sendCmi(r.stim, per);
        default: line.sendRail(r.stim, per, r.mode == 2'h0);
      endcase
      repeat (2 * per) @(posedge core_clk);
      chk(seek(r.exp), r.exp);
    end
    // Consumer stalls while a rail burst overruns the four-word buffer
    @(posedge core_clk);
    pol      <= 1'b0;
    symReady <= 1'b0;
    regWrite(ADDR_CTRL, 8'h05);
    line.sendRail(16'h8961, PER_E1, 1'b0);
    regRead(ADDR_STAT, v);
    chk(16'(v), 16'h000D);
    // Idle clock pin in optical mode adds nothing, so the clear sticks
    regWrite(ADDR_CTRL, 8'h01);
    // A last rail drop may land one cycle after the mode change and would beat the clear
    @(posedge core_clk);
    regWrite(ADDR_STAT, 8'h04);
    regRead(ADDR_STAT, v);
    chk(16'(v), 16'h000A);
    got.delete();
    @(posedge core_clk);
    symReady <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(16'(got.size()), 16'h0004);
    chk(16'(symValid), 16'h0000);
    regWrite(8'h07, 8'hFF);
    regRead(ADDR_CTRL, v);
    chk(16'(v), 16'h0001);
    regRead(8'h07, v);
    chk(16'(v), 16'h0000);
    // Mid-run reset must restore analog mode, active-low inputs and an empty buffer
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    regRead(ADDR_CTRL, v);
    chk(16'(v), 16'(CTRL_RESET));
    regRead(ADDR_STAT, v);
    chk(16'(v), 16'h0000);
    conclude();
  end

  // Whole run takes well under a tenth of this
  initial begin
    #1_000_000;
    numErrors++;
    conclude();
  end
endmodule
